/* logic/ldc_device.sv */
// led driver command decoder end: i2c target, settings, boost gate
`timescale 1ns/1ps
module ldc_device
    import ldc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    ldc_bus_if.device bus,
    input wire logic address_select_pin,
    input wire logic open_load,
    output logic shutdown,
    output logic [ldc_pkg::LEVEL_WIDTH-1:0] led_current_level_reg,
    output logic [ldc_pkg::LEVEL_WIDTH-1:0] dim_target,
    output logic dim_upward,
    output logic [4:0] dim_step_time,
    output logic dim_start,
    output logic [4:0] photo_gain,
    output logic [3:0] photo_min,
    output logic [5:0] photo_timing,
    output logic [4:0] current_mirror,
    output logic switch_node
);
    import ldc_pkg::*;
    typedef enum {
        ST_IDLE, ST_ADDR, ST_SEL, ST_DATA, ST_IGNORE
    } ldc_dev_state_type;

    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;
    logic addr_pin_meta, addr_pin;
    ldc_dev_state_type state;
    logic [7:0] shift;
    logic [3:0] bit_count;
    logic ack_phase;
    logic [3:0] selection;
    logic data_ok;
    // set once a data byte, not the address, owns the ack slot
    logic data_byte;
    logic [4:0] boost_count;
    logic open_meta, open_sync;

    wire scl_rise = scl_sync && !scl_prev;
    wire scl_fall = !scl_sync && scl_prev;
    wire start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
    wire stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;
    wire [7:0] byte_in = shift;
    wire [6:0] my_addr = addr_pin ? ADDR_PIN_HIGH : ADDR_PIN_LOW;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            addr_pin_meta <= 1'b0;
            addr_pin <= 1'b0;
            open_meta <= 1'b0;
            open_sync <= 1'b0;
        end else begin
            scl_meta <= bus.scl;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= bus.sda;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
            addr_pin_meta <= address_select_pin;
            addr_pin <= addr_pin_meta;
            open_meta <= open_load;
            open_sync <= open_meta;
        end
    end

    // byte framing: 8 data bits on scl rise, ack slot as ninth bit
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_count <= 4'h0;
            ack_phase <= 1'b0;
            selection <= 4'h0;
            data_ok <= 1'b0;
            data_byte <= 1'b0;
        end else begin
            data_ok <= 1'b0;
            if (stop_seen) begin
                state <= ST_IDLE;
                bit_count <= 4'h0;
                ack_phase <= 1'b0;
            end else if (start_seen) begin
                state <= ST_ADDR;
                bit_count <= 4'h0;
                ack_phase <= 1'b0;
            end else if (state != ST_IDLE) begin
                if (scl_rise && !ack_phase) begin
                    shift <= {shift[6:0], sda_sync};
                    bit_count <= bit_count + 4'h1;
                end
                if (scl_fall && bit_count == 4'h8 && !ack_phase) begin
                    bit_count <= 4'h0;
                    unique case (state)
                        ST_ADDR: begin
                            if (byte_in[7:1] == my_addr && !byte_in[0]) begin
                                ack_phase <= 1'b1;
                                data_byte <= 1'b0;
                                state <= ST_SEL;
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end
                        ST_SEL: begin
                            ack_phase <= 1'b1;
                            selection <= byte_in[3:0];
                            state <= ST_DATA;
                        end
                        ST_DATA: begin
                            ack_phase <= 1'b1;
                            data_byte <= 1'b1;
                            state <= ST_SEL;
                        end
                        ST_IGNORE: state <= ST_IGNORE;
                        ST_IDLE: state <= ST_IDLE;
                    endcase
                end else if (scl_fall && ack_phase) begin
                    ack_phase <= 1'b0;
                    // data acts at the end of its ack slot
                    // the address ack also leaves state at ST_SEL
                    data_ok <= (state == ST_SEL) && data_byte;
                end
            end
        end
    end

    // the device only pulls sda low in its ack slots
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus.sda_dev_out <= 1'b1;
            bus.sda_dev_oe <= 1'b0;
        end else begin
            bus.sda_dev_out <= 1'b0;
            bus.sda_dev_oe <= ack_phase && !stop_seen;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shutdown <= 1'b1;
            led_current_level_reg <= 5'h00;
            dim_target <= 5'h00;
            dim_upward <= 1'b0;
            dim_step_time <= 5'h00;
            dim_start <= 1'b0;
            photo_gain <= 5'h00;
            photo_min <= 4'h0;
            photo_timing <= 6'h00;
        end else begin
            dim_start <= 1'b0;
            if (data_ok) begin
                unique case (selection)
                    SEL_SHUTDOWN: shutdown <= 1'b1;
                    SEL_LED_NOW: begin
                        shutdown <= 1'b0;
                        led_current_level_reg <= shift[4:0];
                    end
                    SEL_DIM_UP: begin
                        dim_target <= shift[4:0];
                        dim_upward <= 1'b1;
                    end
                    SEL_DIM_DOWN: begin
                        dim_target <= shift[4:0];
                        dim_upward <= 1'b0;
                    end
                    SEL_DIM_START: begin
                        dim_step_time <= shift[4:0];
                        dim_start <= 1'b1;
                        shutdown <= 1'b0;
                    end
                    SEL_PH_GAIN: photo_gain <= shift[4:0];
                    SEL_PH_MIN: photo_min <= shift[3:0];
                    SEL_PH_TIMING: photo_timing <= shift[5:0];
                    default: photo_min <= photo_min;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            current_mirror <= 5'h00;
        end else begin
            current_mirror <= shutdown ? 5'h00 : led_current_level_reg;
        end
    end

    // fixed-period boost switching, halted on open load
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            boost_count <= 5'h00;
            switch_node <= 1'b0;
        end else begin
            if (boost_count == 5'(BOOST_CYCLES - 1)) begin
                boost_count <= 5'h00;
            end else begin
                boost_count <= boost_count + 5'h01;
            end
            switch_node <= !shutdown && !open_sync &&
                (boost_count < 5'(BOOST_ON_CYCLES));
        end
    end
endmodule

/* logic/ldc_pkg.sv */
// shared constants for the led driver i2c command port, both ends
// What this block does
// - device only acknowledges, never sends read data
// - address pin selects one of two target addresses
// - host opens frame with selected write address
// - current update is address, selection, data frame
// - unlimited selection and data pairs per frame
// - only stop ends a transfer
// - selection byte precedes every data byte
// - low nibble selects register, high nibble reserved
// - host never selects factory test code
// - 00 shutdown, 01 current now, 04 dimming start
// - 02 and 03 load dimming target up/down
// - 08, 09, 0a load photo sense settings
// - host avoids reserved selection codes
// - current mirror follows current level register, held at zero in shutdown
// - open load stops boost switching
// - boost switches near 1.3 mhz
// - code 01 applies level at data acknowledge
// - level is bits 4..0, 1f full scale
package ldc_pkg;
    localparam logic [6:0] ADDR_PIN_LOW = 7'h39;
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h3a;
    localparam logic [3:0] SEL_SHUTDOWN = 4'h0;
    localparam logic [3:0] SEL_LED_NOW = 4'h1;
    localparam logic [3:0] SEL_DIM_UP = 4'h2;
    localparam logic [3:0] SEL_DIM_DOWN = 4'h3;
    localparam logic [3:0] SEL_DIM_START = 4'h4;
    localparam logic [3:0] SEL_PH_GAIN = 4'h8;
    localparam logic [3:0] SEL_PH_MIN = 4'h9;
    localparam logic [3:0] SEL_PH_TIMING = 4'ha;
    localparam logic [3:0] SEL_FACTORY = 4'hf;
    localparam logic [4:0] LED_FULL_SCALE = 5'h1f;
    localparam int LEVEL_WIDTH = 5;
    localparam int CLOCK_HZ = 25000000;
    localparam int BOOST_HZ = 1300000;
    // boost period in cycles, rounded down
    localparam int BOOST_CYCLES = CLOCK_HZ / BOOST_HZ;
    localparam int BOOST_ON_CYCLES = BOOST_CYCLES / 2;
    // host divider: 25 mhz / 64 gives about 390 khz scl
    localparam int SCL_HALF_CYCLES = 32;
    // host apb register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_GO = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_ADDR_SEL = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NACK = 1;
endpackage

/* logic/ldc_bus_if.sv */
// i2c wires joining host and device, open drain resolved here
`timescale 1ns/1ps
interface ldc_bus_if;
    logic scl_out;
    logic scl_oe;
    logic sda_host_out;
    logic sda_host_oe;
    logic sda_dev_out;
    logic sda_dev_oe;
    logic scl;
    logic sda;
    assign scl = !(scl_oe && !scl_out);
    assign sda = !((sda_host_oe && !sda_host_out) ||
        (sda_dev_oe && !sda_dev_out));
    modport host (output scl_out, scl_oe, sda_host_out, sda_host_oe,
        input scl, sda);
    modport device (output sda_dev_out, sda_dev_oe, input scl, sda);
endinterface

/* logic/ldc_host.sv */
// host end: apb-driven i2c controller that writes command bytes
`timescale 1ns/1ps
module ldc_host
    import ldc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    ldc_bus_if.host bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import ldc_pkg::*;
    typedef enum {
        H_IDLE, H_START, H_BIT, H_ACK, H_WAIT, H_STOP
    } ldc_host_state_type;

    ldc_host_state_type state;
    logic [7:0] data_reg;
    logic addr_sel;
    logic nack;
    logic [7:0] shift;
    logic [3:0] bit_count;
    logic [5:0] div;
    logic phase;
    logic first_byte;
    logic sda_meta, sda_sync;
    logic go_pending, stop_pending;

    wire access = psel && penable;
    wire wr_ctrl = access && pwrite && paddr == REG_CTRL;
    wire wr_data = access && pwrite && paddr == REG_DATA;
    wire tick = div == 6'(SCL_HALF_CYCLES - 1);
    // queued go, queued stop and the pending first byte all count as busy
    wire busy = go_pending || stop_pending || first_byte ||
        (state != H_IDLE && state != H_WAIT);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            sda_meta <= bus.sda;
            sda_sync <= sda_meta;
        end
    end

    // apb slave: zero wait states, unmapped reads zero with error
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            data_reg <= 8'h00;
            addr_sel <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != REG_CTRL &&
                paddr != REG_DATA && paddr != REG_STATUS;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    REG_DATA: prdata <= {24'h0, data_reg};
                    REG_CTRL: prdata <= {29'h0, addr_sel, 2'b00};
                    REG_STATUS: prdata <= {30'h0, nack, busy};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            if (wr_data && pready) begin
                data_reg <= pwdata[7:0];
            end
            if (wr_ctrl && pready) begin
                addr_sel <= pwdata[CTRL_ADDR_SEL];
            end
        end
    end

    // go sends one byte (address first if no frame is open)
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= H_IDLE;
            shift <= 8'h00;
            bit_count <= 4'h0;
            div <= 6'h00;
            phase <= 1'b0;
            first_byte <= 1'b0;
            nack <= 1'b0;
            go_pending <= 1'b0;
            stop_pending <= 1'b0;
            bus.scl_out <= 1'b1;
            bus.scl_oe <= 1'b0;
            bus.sda_host_out <= 1'b1;
            bus.sda_host_oe <= 1'b0;
        end else begin
            div <= tick ? 6'h00 : div + 6'h01;
            if (wr_ctrl && pready && pwdata[CTRL_GO]) begin
                go_pending <= 1'b1;
            end
            if (wr_ctrl && pready && pwdata[CTRL_STOP]) begin
                stop_pending <= 1'b1;
            end
            if (tick) begin
                unique case (state)
                    H_IDLE: if (go_pending) begin
                        go_pending <= 1'b0;
                        nack <= 1'b0;
                        bus.sda_host_oe <= 1'b1;
                        bus.sda_host_out <= 1'b0;
                        state <= H_START;
                    end
                    H_START: begin
                        bus.scl_oe <= 1'b1;
                        bus.scl_out <= 1'b0;
                        shift <= {addr_sel ? ADDR_PIN_HIGH : ADDR_PIN_LOW,
                            1'b0};
                        first_byte <= 1'b1;
                        bit_count <= 4'h0;
                        phase <= 1'b0;
                        state <= H_BIT;
                    end
                    H_BIT: begin
                        phase <= !phase;
                        if (!phase) begin
                            bus.sda_host_oe <= 1'b1;
                            bus.sda_host_out <= shift[7];
                            bus.scl_out <= 1'b0;
                        end else begin
                            bus.scl_out <= 1'b1;
                        end
                        if (phase && bit_count != 4'h7) begin
                            bit_count <= bit_count + 4'h1;
                        end
                        if (phase) begin
                            shift <= {shift[6:0], 1'b0};
                        end
                        if (phase && bit_count == 4'h7) begin
                            state <= H_ACK;
                        end
                    end
                    H_ACK: begin
                        phase <= !phase;
                        if (!phase) begin
                            bus.scl_out <= 1'b0;
                            bus.sda_host_oe <= 1'b0;
                        end else begin
                            bus.scl_out <= 1'b1;
                            nack <= nack | sda_sync;
                            bit_count <= 4'h0;
                            state <= H_WAIT;
                        end
                    end
                    H_WAIT: begin
                        bus.scl_out <= 1'b0;
                        if (first_byte) begin
                            first_byte <= 1'b0;
                            shift <= data_reg;
                            state <= H_BIT;
                        end else if (go_pending) begin
                            go_pending <= 1'b0;
                            shift <= data_reg;
                            state <= H_BIT;
                        end else if (stop_pending) begin
                            stop_pending <= 1'b0;
                            bus.sda_host_oe <= 1'b1;
                            bus.sda_host_out <= 1'b0;
                            state <= H_STOP;
                        end
                        phase <= 1'b0;
                    end
                    H_STOP: begin
                        phase <= !phase;
                        if (!phase) begin
                            bus.scl_out <= 1'b1;
                        end else begin
                            bus.sda_host_oe <= 1'b0;
                            bus.scl_oe <= 1'b0;
                            state <= H_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule

/* bench/ldc_chk.sv */
// wire-level assertions for the led driver i2c link
`timescale 1ns/1ps
module ldc_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_host_out,
    input wire logic sda_host_oe,
    input wire logic sda_dev_out,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // cycles since scl last went low
    logic [7:0] low_cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 8'h00;
        end else if (scl) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hff) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    sequence stop_seen;
        scl && $rose(sda);
    endsequence
    sequence start_seen;
        scl && $fell(sda);
    endsequence
    chk_dev_low_only: assert property (sda_dev_oe |-> !sda_dev_out)
        else $error("device drove sda high");
    chk_dev_scl_low: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("device sda changed while scl high");
    chk_ack_after_fall: assert property ($rose(sda_dev_oe) |->
        (low_cnt > 8'h00 && low_cnt < 8'h0a))
        else $error("ack not started just after scl fall");
    chk_ack_release: assert property ($fell(scl) && sda_dev_oe |->
        ##[1:10] !sda_dev_oe)
        else $error("ack held past its slot");
    chk_ack_span: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
        else $error("ack too short");
    chk_stop_idle: assert property (stop_seen |-> (!sda_dev_oe)[*8])
        else $error("device drove sda after stop");
    chk_start_hold: assert property (start_seen |-> ##1 scl[*4])
        else $error("scl fell too soon after start");
    chk_scl_high_len: assert property ($rose(scl) |-> scl[*8])
        else $error("scl high phase too short");
endmodule

/* bench/led_driver_i2c_command_port_test.sv */
// bench driving the host over apb and watching the device
`timescale 1ns/1ps
module led_driver_i2c_command_port_test;
    import ldc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic address_select_pin = 1'b0;
    logic open_load = 1'b0;
    logic shutdown, dim_upward, dim_start, switch_node;
    logic [4:0] led_current_level_reg, dim_target, dim_step_time;
    logic [4:0] photo_gain, current_mirror;
    logic [3:0] photo_min;
    logic [5:0] photo_timing;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;
    logic asel = 1'b0;
    logic [7:0] shreg = 8'h00;
    logic [7:0] addr_seen = 8'h00;
    int bitn = 9;
    int rises = 0;
    int r0;
    logic dev_bad = 1'b0;
    logic started = 1'b0;
    logic pscl = 1'b1;
    logic psda = 1'b1;
    logic psw = 1'b0;
    logic [7:0] sel_t [6] = '{8'h03, 8'h04, 8'h08, 8'h09, 8'h0a,
        8'h02};
    logic [7:0] dat_t [6] = '{8'h05, 8'h13, 8'h15, 8'h07, 8'h2c, 8'h0a};
    logic [7:0] rsv_t [4] = '{8'h05, 8'h07, 8'h0b, 8'h0e};
    ldc_bus_if bus_if();
    ldc_host u_ldc_host (.clock(clock), .nrst(nrst), .bus(bus_if),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    ldc_device u_ldc_device (.clock(clock), .nrst(nrst), .bus(bus_if),
        .address_select_pin(address_select_pin), .open_load(open_load),
        .shutdown(shutdown), .led_current_level_reg(led_current_level_reg),
        .dim_target(dim_target), .dim_upward(dim_upward),
        .dim_step_time(dim_step_time), .dim_start(dim_start),
        .photo_gain(photo_gain), .photo_min(photo_min),
        .photo_timing(photo_timing), .current_mirror(current_mirror),
        .switch_node(switch_node));
    ldc_chk u_ldc_chk (.clock(clock), .nrst(nrst), .scl_out(bus_if.scl_out),
        .scl_oe(bus_if.scl_oe), .sda_host_out(bus_if.sda_host_out),
        .sda_host_oe(bus_if.sda_host_oe), .sda_dev_out(bus_if.sda_dev_out),
        .sda_dev_oe(bus_if.sda_dev_oe), .scl(bus_if.scl), .sda(bus_if.sda));
    always #20 clock = ~clock;
    // wire monitor: first byte after start, device drive, boost edges
    always @(posedge clock) begin
        if (bus_if.sda_dev_oe && bus_if.sda_dev_out) begin
            dev_bad <= 1'b1;
        end
        if (dim_start) begin
            started <= 1'b1;
        end
        if (switch_node && !psw) begin
            rises <= rises + 1;
        end
        if (bus_if.scl && pscl && psda && !bus_if.sda) begin
            bitn <= 0;
        end else if (bus_if.scl && !pscl && bitn < 8) begin
            shreg <= {shreg[6:0], bus_if.sda};
            bitn <= bitn + 1;
        end else if (bitn == 8) begin
            addr_seen <= shreg;
            bitn <= 9;
        end
        pscl <= bus_if.scl;
        psda <= bus_if.sda;
        psw <= switch_node;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            chk("pready", 8'h01, 8'h00);
            end_sim();
        end
    endtask
    task automatic send(input logic [7:0] b, input logic stp);
        int i;
        apb(1'b1, REG_DATA, {24'h0, b});
        apb(1'b1, REG_CTRL, {29'h0, asel, stp, 1'b1});
        for (i = 0; i < 3000; i++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[STAT_BUSY] === 1'b0) break;
        end
        if (i == 3000) begin
            chk("busy", 8'h00, 8'h01);
            end_sim();
        end
    endtask
    task automatic pair(input logic [7:0] s, input logic [7:0] d,
        input logic stp);
        send(s, 1'b0);
        send(d, stp);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        chk("shutdown", 8'h01, 8'(shutdown));
        chk("mirror", 8'h00, 8'(current_mirror));
        apb(1'b0, 8'h0c, 32'h0);
        chk("slverr", 8'h01, 8'(err));
        chk("unmapped", 8'h00, rd[7:0]);
        $display("test reset done");
        pair(8'h01, 8'he3, 1'b1);
        chk("addr", 8'h72, addr_seen);
        chk("level", 8'h03, 8'(led_current_level_reg));
        chk("shutdown", 8'h00, 8'(shutdown));
        chk("mirror", 8'h03, 8'(current_mirror));
        pair(8'h51, 8'h1f, 1'b1);
        chk("level", 8'h1f, 8'(led_current_level_reg));
        $display("test immediate level done");
        foreach (sel_t[i]) pair(sel_t[i], dat_t[i], i == 5);
        chk("target", 8'h0a, 8'(dim_target));
        chk("upward", 8'h01, 8'(dim_upward));
        chk("step", 8'h13, 8'(dim_step_time));
        chk("started", 8'h01, 8'(started));
        chk("gain", 8'h15, 8'(photo_gain));
        chk("min", 8'h07, 8'(photo_min));
        chk("timing", 8'h2c, 8'(photo_timing));
        $display("test multi pair done");
        foreach (rsv_t[i]) pair(rsv_t[i], 8'h02, 1'b0);
        pair(8'h03, 8'h04, 1'b1);
        chk("nack", 8'h00, 8'(rd[STAT_NACK]));
        chk("level", 8'h1f, 8'(led_current_level_reg));
        chk("gain", 8'h15, 8'(photo_gain));
        chk("step", 8'h13, 8'(dim_step_time));
        chk("target", 8'h04, 8'(dim_target));
        chk("upward", 8'h00, 8'(dim_upward));
        $display("test reserved done");
        r0 = rises;
        repeat (BOOST_CYCLES * 10) @(posedge clock);
        chk("boost", 8'h0a, 8'(rises - r0));
        open_load <= 1'b1;
        repeat (8) @(posedge clock);
        r0 = rises;
        repeat (100) @(posedge clock);
        chk("open", 8'h00, 8'(rises - r0));
        open_load <= 1'b0;
        $display("test boost done");
        address_select_pin <= 1'b1;
        send(8'h01, 1'b1);
        chk("nack", 8'h01, 8'(rd[STAT_NACK]));
        chk("level", 8'h1f, 8'(led_current_level_reg));
        asel = 1'b1;
        pair(8'h01, 8'h0c, 1'b1);
        chk("addr", 8'h74, addr_seen);
        chk("level", 8'h0c, 8'(led_current_level_reg));
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 8'h04, rd[7:0] & 8'h04);
        $display("test address pin done");
        pair(8'h00, 8'h00, 1'b1);
        chk("shutdown", 8'h01, 8'(shutdown));
        chk("mirror", 8'h00, 8'(current_mirror));
        chk("dev_drive", 8'h00, 8'(dev_bad));
        $display("test shutdown done");
        end_sim();
    end
endmodule
